// [acm_defs.svh]
// Constants for the converter setup logic
`ifndef ACM_DEFS_SVH
`define ACM_DEFS_SVH
`define ACM_W            10
`define ACM_RST_WORD     10'h020
`define ACM_BIT_VREF     0
`define ACM_BIT_MODE     1
`define ACM_BIT_PD       2
`define ACM_CHSEL_LO     3
`define ACM_CHSEL_HI     4
`define ACM_DIFF_LO      5
`define ACM_DIFF_HI      6
`define ACM_BIT_SCAN     7
`define ACM_TEST_LO      8
`define ACM_TEST_HI      9
`define ACM_ADDR_SETUP   2'h0
`define ACM_CFG_POSITIVE_ANALOG_INPUT     5'h00
`define ACM_CFG_NEGATIVE_ANALOG_INPUT     5'h01
`define ACM_CFG_DIFF     5'h04
`define ACM_CFG_SCAN     5'h11
`define ACM_CNT_W        4
`define ACM_CNT_ONE      4'h1
`define ACM_CNT_ZERO     4'h0
`endif

// [acm_pkg.sv]
// Types for the converter setup logic
`default_nettype none
package acm_pkg;
  typedef enum logic [1:0] {
    ACM_IN_POS  = 2'b00,
    ACM_IN_NEG  = 2'b01,
    ACM_IN_DIFF = 2'b10,
    ACM_IN_NONE = 2'b11
  } acm_input_t;
  typedef enum logic [1:0] {
    ACM_TST_NORMAL = 2'b00,
    ACM_TST_UPPER  = 2'b01,
    ACM_TST_MID    = 2'b10,
    ACM_TST_LOWER  = 2'b11
  } acm_test_t;
  typedef struct packed {
    logic       sample_hold;
    logic       sample_write;
    acm_input_t input_sel;
    acm_test_t  test_sel;
  } acm_conv_t;
endpackage
`default_nettype wire

// [acm_edge_sync.sv]
// Two-stage synchroniser with falling-edge detector
`timescale 1ns/1ps
`default_nettype none
module acm_edge_sync
  import acm_pkg::*;
(
  // Clock and reset
  input  wire logic i_mclk,
  input  wire logic i_arst_n,
  // Pin and results
  input  wire logic i_pin,
  output logic      o_level,
  output logic      o_fall
);
  logic meta_q;
  logic meta_d;
  logic sync_q;
  logic sync_d;
  logic prev_q;
  logic prev_d;
  always_comb begin
    meta_d = i_pin;
    sync_d = meta_q;
    prev_d = sync_q;
  end
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
      prev_q <= prev_d;
    end
  end
  assign o_level = sync_q;
  assign o_fall  = prev_q & ~sync_q;
endmodule
`default_nettype wire

// [acm_setup.sv]
// Setup word decode and conversion sequencing
`timescale 1ns/1ps
`default_nettype none
`include "acm_defs.svh"
// Functional notes
// - Single mode: clock pin acts as start strobe
// - Strobe fall holds all inputs together
// - Data available only when trigger met
// - Bit 2 powers down, resets zero
// - Writes and reads work while powered down
// - Bits 3,4 select channel, reset zero
// - Bits 5,6 differential count, reset 1,0
// - Bit 7 enables autoscan, resets zero
// - Zero config positive input; select low negative
// - Differential low bit alone: difference channel
// - Autoscan alternates positive then negative
// - Bits 8,9 pick test voltage
// - Continuous mode: sample per clock falling edge
module acm_setup
  import acm_pkg::*;
(
  // Clock and reset
  input  wire logic        i_mclk,
  input  wire logic        i_arst_n,
  // Host write port
  input  wire logic        i_wr_strobe,
  input  wire logic        i_register_address_bit_low,
  input  wire logic        i_register_address_bit_high,
  input  wire logic [9:0]  i_wr_data,
  // Conversion clock pin and FIFO status
  input  wire logic        i_conversion_clock_pin,
  input  wire logic        i_trigger_met,
  // Decoded setup
  output logic             o_power_down_bit,
  output logic             o_ext_ref_sel,
  output logic             o_single_mode,
  output logic [9:0]       o_converter_setup_word,
  output logic             o_config_valid,
  // Conversion control
  output acm_conv_t        o_conv,
  output logic             o_data_available_output
);
  ////////////////////////////////////////////////////////////////////////////
  // Setup word register
  logic [9:0] setup_q;
  logic [9:0] setup_d;
  logic       wr_hit;
  assign wr_hit = i_wr_strobe && ({i_register_address_bit_high, i_register_address_bit_low} == `ACM_ADDR_SETUP);
  always_comb begin
    setup_d = setup_q;
    if (wr_hit) begin
      setup_d = i_wr_data;
    end
  end
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      setup_q <= `ACM_RST_WORD;
    end else begin
      setup_q <= setup_d;
    end
  end
  logic [4:0] cfg;
  assign cfg = {setup_q[`ACM_BIT_SCAN], setup_q[`ACM_DIFF_HI], setup_q[`ACM_DIFF_LO],
                setup_q[`ACM_CHSEL_HI], setup_q[`ACM_CHSEL_LO]};
  assign o_converter_setup_word = setup_q;
  assign o_power_down_bit = setup_q[`ACM_BIT_PD];
  assign o_ext_ref_sel    = setup_q[`ACM_BIT_VREF];
  assign o_single_mode    = setup_q[`ACM_BIT_MODE];
  ////////////////////////////////////////////////////////////////////////////
  // Strobe edge
  logic pin_fall;
  acm_edge_sync u_clk_sync (
    .i_mclk   (i_mclk),
    .i_arst_n (i_arst_n),
    .i_pin    (i_conversion_clock_pin),
    .o_level  (),
    .o_fall   (pin_fall)
  );
  ////////////////////////////////////////////////////////////////////////////
  // Conversion sequencing
  logic       scan_neg_q;
  logic       scan_neg_d;
  acm_conv_t  conv_q;
  acm_conv_t  conv_d;
  logic       avail_q;
  logic       avail_d;
  logic       active;
  acm_input_t in_sel;
  assign active = pin_fall && !setup_q[`ACM_BIT_PD];
  always_comb begin
    o_config_valid = 1'b1;
    unique case (cfg)
      `ACM_CFG_POSITIVE_ANALOG_INPUT: in_sel = ACM_IN_POS;
      `ACM_CFG_NEGATIVE_ANALOG_INPUT: in_sel = ACM_IN_NEG;
      `ACM_CFG_DIFF: in_sel = ACM_IN_DIFF;
      `ACM_CFG_SCAN: in_sel = scan_neg_q ? ACM_IN_NEG : ACM_IN_POS;
      default: begin
        in_sel         = ACM_IN_NONE;
        o_config_valid = 1'b0;
      end
    endcase
  end
  always_comb begin
    scan_neg_d = scan_neg_q;
    if (cfg != `ACM_CFG_SCAN) begin
      scan_neg_d = 1'b0;
    end else if (active) begin
      scan_neg_d = ~scan_neg_q;
    end
    conv_d.sample_hold  = active && setup_q[`ACM_BIT_MODE];
    conv_d.sample_write = active && !setup_q[`ACM_BIT_MODE];
    conv_d.input_sel    = in_sel;
    conv_d.test_sel     = acm_test_t'(setup_q[`ACM_TEST_HI:`ACM_TEST_LO]);
    avail_d = setup_q[`ACM_BIT_MODE] ? i_trigger_met : 1'b0;
  end
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      scan_neg_q <= 1'b0;
      conv_q     <= '{1'b0, 1'b0, ACM_IN_POS, ACM_TST_NORMAL};
      avail_q    <= 1'b0;
    end else begin
      scan_neg_q <= scan_neg_d;
      conv_q     <= conv_d;
      avail_q    <= avail_d;
    end
  end
  assign o_conv = conv_q;
  assign o_data_available_output = avail_q;
  ////////////////////////////////////////////////////////////////////////////
  // Assertions: setup word
  setup_write_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    wr_hit |=> setup_q == $past(i_wr_data)) else $error("setup write lost");
  word_keep_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    !wr_hit |=> $stable(o_converter_setup_word)) else $error("setup word changed");
  ext_keep_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    !wr_hit |=> $stable(o_ext_ref_sel)) else $error("reference select changed");
  pd_write_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    (o_power_down_bit && wr_hit) |=> o_converter_setup_word == $past(i_wr_data))
    else $error("write lost while down");
  pd_keep_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    !wr_hit |=> $stable(o_power_down_bit)) else $error("power state changed");
  mode_keep_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    !wr_hit |=> $stable(o_single_mode)) else $error("mode changed");
  test_sel_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    !wr_hit |=> o_conv.test_sel == setup_q[`ACM_TEST_HI:`ACM_TEST_LO]) else $error("test sel wrong");
  ////////////////////////////////////////////////////////////////////////////
  // Assertions: strobe path and pulses
  sync_lag_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    pin_fall |-> !$past(i_conversion_clock_pin, 2)) else $error("strobe edge early");
  hold_edge_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    (pin_fall && setup_q[`ACM_BIT_MODE] && !setup_q[`ACM_BIT_PD] && !wr_hit) |=> o_conv.sample_hold)
    else $error("hold missed");
  write_off_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    !pin_fall |=> !(o_conv.sample_hold || o_conv.sample_write))
    else $error("pulse without strobe edge");
  hold_single_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    (pin_fall && o_single_mode && !o_power_down_bit) |=> !o_conv.sample_write)
    else $error("single edge gave write");
  hold_pulse_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    o_conv.sample_hold |=> !o_conv.sample_hold) else $error("hold not a pulse");
  hold_mode_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    o_conv.sample_hold |-> $past(o_single_mode)) else $error("hold outside single mode");
  cont_pulse_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    (pin_fall && !o_single_mode && !o_power_down_bit) |=> o_conv.sample_write)
    else $error("write missed");
  cont_write_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    o_conv.sample_write |-> !o_single_mode || $past(wr_hit)) else $error("write in single mode");
  write_mode_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    o_conv.sample_write |-> !$past(o_single_mode)) else $error("write outside continuous mode");
  write_pulse_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    o_conv.sample_write |=> !o_conv.sample_write) else $error("write not a pulse");
  pd_block_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    (o_power_down_bit && !wr_hit) |=> !(o_conv.sample_hold || o_conv.sample_write))
    else $error("convert while down");
  pd_scan_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    (o_power_down_bit && cfg == `ACM_CFG_SCAN) |=> $stable(scan_neg_q))
    else $error("scan moved while down");
  ////////////////////////////////////////////////////////////////////////////
  // Assertions: data available
  avail_trig_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    o_data_available_output |-> $past(i_trigger_met)) else $error("avail without trigger");
  avail_set_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    (o_single_mode && i_trigger_met) |=> o_data_available_output) else $error("avail missed");
  avail_idle_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    !i_trigger_met |=> !o_data_available_output) else $error("avail without level");
  avail_cont_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    !o_single_mode |=> !o_data_available_output) else $error("avail in continuous mode");
  avail_pd_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    (o_power_down_bit && o_single_mode && i_trigger_met) |=> o_data_available_output)
    else $error("avail lost while down");
  ////////////////////////////////////////////////////////////////////////////
  // Assertions: input selection
  legal_cfg_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    (cfg == `ACM_CFG_POSITIVE_ANALOG_INPUT || cfg == `ACM_CFG_NEGATIVE_ANALOG_INPUT || cfg == `ACM_CFG_DIFF || cfg == `ACM_CFG_SCAN)
    |-> o_config_valid) else $error("legal config refused");
  reserved_sel_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    !o_config_valid |=> o_conv.input_sel == ACM_IN_NONE) else $error("reserved config converted");
  sel_keep_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    (cfg != `ACM_CFG_SCAN && !wr_hit) |=> ##1 $stable(o_conv.input_sel))
    else $error("input choice drifted");
  positive_analog_input_sel_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    (cfg == `ACM_CFG_POSITIVE_ANALOG_INPUT) |=> o_conv.input_sel == ACM_IN_POS) else $error("positive input not chosen");
  negative_analog_input_sel_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    (cfg == `ACM_CFG_NEGATIVE_ANALOG_INPUT) |=> o_conv.input_sel == ACM_IN_NEG) else $error("negative input not chosen");
  diff_sel_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    (cfg == `ACM_CFG_DIFF && !wr_hit) |=> o_conv.input_sel == ACM_IN_DIFF) else $error("diff not chosen");
  scan_alt_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    (cfg == `ACM_CFG_SCAN && active && !wr_hit) |=> scan_neg_q != $past(scan_neg_q))
    else $error("scan no alternate");
  scan_keep_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    (cfg == `ACM_CFG_SCAN && !active) |=> $stable(scan_neg_q)) else $error("scan moved without edge");
  scan_pos_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    (cfg == `ACM_CFG_SCAN && !scan_neg_q) |=> o_conv.input_sel == ACM_IN_POS)
    else $error("scan lost positive");
  scan_neg_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    (cfg == `ACM_CFG_SCAN && scan_neg_q) |=> o_conv.input_sel == ACM_IN_NEG)
    else $error("scan lost negative");
  scan_home_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    (cfg != `ACM_CFG_SCAN) |=> !scan_neg_q) else $error("scan order not reset");
endmodule
`default_nettype wire

// [acm_host_model.sv]
// Host processor model driving the setup port, clock pin and FIFO level
`timescale 1ns/1ps
`default_nettype none
module acm_host_model (
  // Clock
  input  wire logic       i_mclk,
  // Host write port
  output logic            o_wr_strobe,
  output logic            o_ra_lo,
  output logic            o_ra_hi,
  output logic [9:0]      o_wr_data,
  // Pin and FIFO level
  output logic            o_pin,
  output logic            o_trigger_met
);
  initial begin
    o_wr_strobe   = 1'b0;
    o_ra_lo       = 1'b1;
    o_ra_hi       = 1'b1;
    o_wr_data     = 10'h155;
    o_pin         = 1'b1;
    o_trigger_met = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////
  // One write cycle; released data and low address lines show the inverse of the last value, high address line keeps it
  task automatic write(input logic [1:0] addr, input logic [9:0] data);
    @(negedge i_mclk);
    o_ra_lo     = addr[0];
    o_ra_hi     = addr[1];
    o_wr_data   = data;
    o_wr_strobe = 1'b1;
    @(negedge i_mclk);
    o_wr_strobe = 1'b0;
    o_ra_lo     = ~addr[0];
    o_wr_data   = ~data;
  endtask
  task automatic pin(input logic v);
    @(negedge i_mclk);
    o_pin = v;
  endtask
  task automatic trig(input logic v);
    @(negedge i_mclk);
    o_trigger_met = v;
  endtask
endmodule
`default_nettype wire

// [adc_channel_mode_config_tb.sv]
// Testbench for the converter setup logic
`timescale 1ns/1ps
`default_nettype none
module adc_channel_mode_config_tb;
  import acm_pkg::*;
  logic       mclk, arst_n, wr, ra_lo, ra_hi, pin, trig;
  logic       pd, vref, single, cvalid, dav;
  logic [9:0] wdata, word;
  logic [1:0] sel_seen;
  acm_conv_t  conv;
  int         n_errors, compares, n_hold, n_wr;
  logic [4:0] cfg [4] = '{5'h00, 5'h01, 5'h04, 5'h11};
  logic [1:0] esel [4] = '{2'b00, 2'b01, 2'b10, 2'b00};
  acm_setup u_dut (.i_mclk(mclk), .i_arst_n(arst_n), .i_wr_strobe(wr),
    .i_register_address_bit_low(ra_lo), .i_register_address_bit_high(ra_hi),
    .i_wr_data(wdata), .i_conversion_clock_pin(pin), .i_trigger_met(trig),
    .o_power_down_bit(pd), .o_ext_ref_sel(vref), .o_single_mode(single),
    .o_converter_setup_word(word), .o_config_valid(cvalid), .o_conv(conv),
    .o_data_available_output(dav));
  acm_host_model u_host (.i_mclk(mclk), .o_wr_strobe(wr), .o_ra_lo(ra_lo),
    .o_ra_hi(ra_hi), .o_wr_data(wdata), .o_pin(pin), .o_trigger_met(trig));
  ////////////////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  initial begin
    #100us;
    n_errors++;
    report_and_stop();
  end
  task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Pin fall, then count hold and write pulses
  task automatic fire();
    n_hold = 0;
    n_wr = 0;
    u_host.pin(1'b0);
    repeat (6) begin
      @(negedge mclk);
      if (conv.sample_hold === 1'b1) n_hold++;
      if (conv.sample_write === 1'b1) n_wr++;
      if ((conv.sample_hold | conv.sample_write) === 1'b1) sel_seen = conv.input_sel;
    end
    u_host.pin(1'b1);
    repeat (3) @(negedge mclk);
  endtask
  task automatic report_and_stop();
    $display("errors=%0d compares=%0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    arst_n = 1'b0;
    repeat (5) @(negedge mclk);
    arst_n = 1'b1;
    chk(word, 10'h020);
    chk({pd, single, vref, cvalid}, 4'b0001);
    for (int a = 1; a < 4; a++) u_host.write(a[1:0], 10'h3FF);
    @(negedge mclk);
    chk(word, 10'h020);
    for (int i = 0; i < 4; i++) begin
      u_host.write(2'h0, {2'h0, cfg[i], 3'h0});
      @(negedge mclk);
      chk(cvalid, 1'b1);
      fire();
      chk({4'h0, n_hold[1:0], n_wr[1:0], sel_seen}, {6'h01, esel[i]});
      if (i == 3) begin
        fire();
        chk({4'h0, n_hold[1:0], n_wr[1:0], sel_seen}, 10'h005);
      end
    end
    for (int t = 0; t < 4; t++) begin
      u_host.write(2'h0, {t[1:0], 8'h00});
      @(negedge mclk);
      chk(conv.test_sel, t[1:0]);
    end
    u_host.write(2'h0, 10'h001);
    chk(vref, 1'b1);
    u_host.write(2'h0, 10'h002);
    fire();
    chk({n_hold[1:0], n_wr[1:0]}, 4'h4);
    chk(dav, 1'b0);
    u_host.trig(1'b1);
    @(negedge mclk);
    chk(dav, 1'b1);
    u_host.write(2'h0, 10'h000);
    repeat (2) @(negedge mclk);
    chk(dav, 1'b0);
    u_host.trig(1'b0);
    u_host.write(2'h0, 10'h004);
    u_host.write(2'h0, 10'h006);
    @(negedge mclk);
    chk({pd, single}, 2'b11);
    fire();
    chk({n_hold[1:0], n_wr[1:0]}, 4'h0);
    report_and_stop();
  end
endmodule
`default_nettype wire
